// file: hw/cdmp_regs.svh
/*
  Register map, field positions, encodings and reset values of the data memory port.
  Assumes it is included by bare name from the package and the design file.
*/
// Overview of operation
// - Drive 32-bit address, changing in access cycle.
// - Address group floats when enable low, unless split.
// - Write bus floats when enable low, unless split.
// - Memory abort input is taken for the access.
// - Write data valid across the whole access cycle.
// - Split low: drive writes only; high: always.
// - Flag write transfer on the write bus.
// - Lock marks next access; memory holds others off.
// - Size code: word 10, half 01, byte 00.
// - Burst hint when a sequential access follows.
// - Output 5-bit mode of the access.
// - Request low one cycle before each access.
// - Direction low read, high write, one ahead.
// - Privilege low user, high privileged access.
// - Sequential high when access continues previous one.
`ifndef CDMP_REGS_SVH
`define CDMP_REGS_SVH

`define CDMP_REG_ADDR 8'h00
`define CDMP_REG_WDATA 8'h04
`define CDMP_REG_CTRL 8'h08
`define CDMP_REG_PUSH 8'h0c
`define CDMP_REG_STATUS 8'h10
`define CDMP_REG_RDATA 8'h14

`define CDMP_CTRL_W 12
`define CDMP_CTRL_WR 0
`define CDMP_CTRL_SIZE_LO 1
`define CDMP_CTRL_LOCK 3
`define CDMP_CTRL_SEQ 4
`define CDMP_CTRL_BURST 5
`define CDMP_CTRL_PRIV 6
`define CDMP_CTRL_MODE_LO 7
`define CDMP_CTRL_RST 12'h000

`define CDMP_ST_ABORT 0
`define CDMP_ST_SIZEERR 1
`define CDMP_ST_OVFL 2
`define CDMP_ST_RDVALID 3
`define CDMP_ST_HALT 4
`define CDMP_ST_FULL 5
`define CDMP_ST_LEVEL_LO 8

`define CDMP_SIZE_BYTE 2'h0
`define CDMP_SIZE_HALF 2'h1
`define CDMP_SIZE_WORD 2'h2
`define CDMP_SIZE_RSVD 2'h3

`define CDMP_MODE_RST 5'h10
`define CDMP_FIFO_DEPTH 8
`define CDMP_LEVEL_W 4

`endif

// file: hw/cdmp_pkg.sv
/*
  Types shared by the data memory port.
  Assumes cdmp_regs.svh is on the include path.
*/
`include "cdmp_regs.svh"

package cdmp_pkg;

  typedef enum logic [0:0] {CDMP_ISSUE, CDMP_HALT} cdmp_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [`CDMP_CTRL_W-1:0] ctrl;
  } cdmp_cmd_s;

  // The reserved size code must never reach the pins, so it is turned into a word access.
  function automatic logic [`CDMP_CTRL_W-1:0] cdmpFixCtrl(input logic [`CDMP_CTRL_W-1:0] c);
    logic [`CDMP_CTRL_W-1:0] r;
    r = c;
    if (c[`CDMP_CTRL_SIZE_LO +: 2] == `CDMP_SIZE_RSVD) begin
      r[`CDMP_CTRL_SIZE_LO +: 2] = `CDMP_SIZE_WORD;
    end
    return r;
  endfunction : cdmpFixCtrl

endpackage : cdmp_pkg

// file: hw/cdmp_data_port.sv
/*
  Data memory port: command FIFO and the pipelined data memory interface logic.
  Assumes one 20 MHz clock, asynchronous active-high reset, a simple register port
  master, and an outside pad ring that resolves the drivers from the active-low enables.
*/
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cdmp_regs.svh"

module cdmp_fifo #(
  parameter int WIDTH = 76,
  parameter int DEPTH = `CDMP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic doPush, doPop;

  assign inReady = (count_r != CW'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];
  assign level = count_r;
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_comb begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (doPush) begin
      wrPtr_nxt = (wrPtr_r == PW'(DEPTH - 1)) ? '0 : PW'(wrPtr_r + 1'b1);
    end
    if (doPop) begin
      rdPtr_nxt = (rdPtr_r == PW'(DEPTH - 1)) ? '0 : PW'(rdPtr_r + 1'b1);
    end
    if (doPush && !doPop) begin
      count_nxt = CW'(count_r + 1'b1);
    end else if (doPop && !doPush) begin
      count_nxt = CW'(count_r - 1'b1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage carries no reset so it can map onto plain RAM cells.
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_r[wrPtr_r] <= inData;
    end
  end
endmodule : cdmp_fifo

module cdmp_data_port
  import cdmp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [31:0] busRdata,
  output logic cmdSpaceAvail,
  output logic [31:0] dmemAddr,
  output logic addrGroupOeN,
  output logic [1:0] accessSize,
  output logic readNWrite,
  output logic dmemLocked,
  output logic privilegedAccess,
  output logic [4:0] accessMode,
  output logic dmemReqN,
  output logic dmemSequential,
  output logic burstFollows,
  output logic [31:0] writeDataOut,
  output logic writeDataOeN,
  output logic writeDataDriven,
  input wire logic [31:0] readDataIn,
  input wire logic dmemAbort,
  input wire logic addrBusDriveEn,
  input wire logic writeBusDriveEn,
  input wire logic splitBusSelect
);
  localparam int LW = `CDMP_LEVEL_W;

  // Pin synchronisers; stage one is read only by stage two.
  logic abe1_r, abe2_r, ddbe1_r, ddbe2_r, split1_r, split2_r, abt1_r, abt2_r;
  logic [31:0] rdIn1_r, rdIn2_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abe1_r <= 1'b0;
      abe2_r <= 1'b0;
      ddbe1_r <= 1'b0;
      ddbe2_r <= 1'b0;
      split1_r <= 1'b0;
      split2_r <= 1'b0;
      abt1_r <= 1'b0;
      abt2_r <= 1'b0;
      rdIn1_r <= '0;
      rdIn2_r <= '0;
    end else begin
      abe1_r <= addrBusDriveEn;
      abe2_r <= abe1_r;
      ddbe1_r <= writeBusDriveEn;
      ddbe2_r <= ddbe1_r;
      split1_r <= splitBusSelect;
      split2_r <= split1_r;
      abt1_r <= dmemAbort;
      abt2_r <= abt1_r;
      rdIn1_r <= readDataIn;
      rdIn2_r <= rdIn1_r;
    end
  end

  logic [31:0] addrReg_r, addrReg_nxt, wdataReg_r, wdataReg_nxt;
  logic [`CDMP_CTRL_W-1:0] ctrlReg_r, ctrlReg_nxt;
  logic [31:0] busRdata_r, busRdata_nxt, rdLast_r, rdLast_nxt;
  logic abortFlag_r, abortFlag_nxt, sizeErr_r, sizeErr_nxt, ovfl_r, ovfl_nxt;
  logic rdValid_r, rdValid_nxt, spaceAvail_r;
  cdmp_state_e state_r, state_nxt;

  logic pushValid, pushReady, popValid, popReady, doPop;
  cdmp_cmd_s pushCmd, popCmd;
  logic [LW-1:0] level;

  logic [31:0] curAddr_r, curAddr_nxt, curWdata_r, curWdata_nxt;
  logic [31:0] dmemAddr_r, dmemAddr_nxt, wdOut_r, wdOut_nxt;
  logic [1:0] size_r, size_nxt;
  logic [4:0] mode_r, mode_nxt;
  logic reqN_r, reqN_nxt, rnw_r, rnw_nxt, lock_r, lock_nxt, priv_r, priv_nxt;
  logic seq_r, seq_nxt, burst_r, burst_nxt;
  logic acc_r, acc_nxt, wrDrv_r, wrDrv_nxt, aOeN_r, aOeN_nxt, wOeN_r, wOeN_nxt;
  logic tagS1_r, tagS1_nxt, tagS2_r, tagS2_nxt, rdS1_r, rdS1_nxt, rdS2_r, rdS2_nxt;

  assign pushValid = busWr && (busAddr == `CDMP_REG_PUSH);
  assign pushCmd = '{addr: addrReg_r, wdata: wdataReg_r, ctrl: cdmpFixCtrl(ctrlReg_r)};
  assign popReady = (state_r == CDMP_ISSUE);
  assign doPop = popValid && popReady;

  cdmp_fifo #(.WIDTH($bits(cdmp_cmd_s)), .DEPTH(`CDMP_FIFO_DEPTH)) cmdFifo (
    .clk(clk),
    .rst(rst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushCmd),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popCmd),
    .level(level)
  );

  // Register port and status.
  always_comb begin
    addrReg_nxt = addrReg_r;
    wdataReg_nxt = wdataReg_r;
    ctrlReg_nxt = ctrlReg_r;
    abortFlag_nxt = abortFlag_r;
    sizeErr_nxt = sizeErr_r;
    ovfl_nxt = ovfl_r;
    rdValid_nxt = rdValid_r;
    rdLast_nxt = rdLast_r;
    busRdata_nxt = '0;
    if (busWr) begin
      unique case (busAddr)
        `CDMP_REG_ADDR: addrReg_nxt = busWdata;
        `CDMP_REG_WDATA: wdataReg_nxt = busWdata;
        `CDMP_REG_CTRL: ctrlReg_nxt = busWdata[`CDMP_CTRL_W-1:0];
        `CDMP_REG_STATUS: begin
          abortFlag_nxt = abortFlag_r && !busWdata[`CDMP_ST_ABORT];
          sizeErr_nxt = sizeErr_r && !busWdata[`CDMP_ST_SIZEERR];
          ovfl_nxt = ovfl_r && !busWdata[`CDMP_ST_OVFL];
          rdValid_nxt = rdValid_r && !busWdata[`CDMP_ST_RDVALID];
        end
        default: ;
      endcase
    end
    // Hardware sets come last so an event in the clearing cycle is kept.
    if (pushValid && (ctrlReg_r[`CDMP_CTRL_SIZE_LO +: 2] == `CDMP_SIZE_RSVD)) begin
      sizeErr_nxt = 1'b1;
    end
    if (pushValid && !pushReady) begin
      ovfl_nxt = 1'b1;
    end
    if (tagS2_r && abt2_r) begin
      abortFlag_nxt = 1'b1;
    end else if (tagS2_r && rdS2_r) begin
      rdLast_nxt = rdIn2_r;
      rdValid_nxt = 1'b1;
    end
    if (busRd) begin
      unique case (busAddr)
        `CDMP_REG_ADDR: busRdata_nxt = addrReg_r;
        `CDMP_REG_WDATA: busRdata_nxt = wdataReg_r;
        `CDMP_REG_CTRL: busRdata_nxt = 32'(ctrlReg_r);
        `CDMP_REG_STATUS: begin
          busRdata_nxt[`CDMP_ST_ABORT] = abortFlag_r;
          busRdata_nxt[`CDMP_ST_SIZEERR] = sizeErr_r;
          busRdata_nxt[`CDMP_ST_OVFL] = ovfl_r;
          busRdata_nxt[`CDMP_ST_RDVALID] = rdValid_r;
          busRdata_nxt[`CDMP_ST_HALT] = (state_r == CDMP_HALT);
          busRdata_nxt[`CDMP_ST_FULL] = !pushReady;
          busRdata_nxt[`CDMP_ST_LEVEL_LO +: LW] = level;
        end
        `CDMP_REG_RDATA: busRdata_nxt = rdLast_r;
        default: busRdata_nxt = '0;
      endcase
    end
  end

  // Issue pipeline: attributes one cycle ahead, then address and write data.
  always_comb begin
    state_nxt = state_r;
    curAddr_nxt = curAddr_r;
    curWdata_nxt = curWdata_r;
    size_nxt = size_r;
    mode_nxt = mode_r;
    rnw_nxt = rnw_r;
    priv_nxt = priv_r;
    reqN_nxt = 1'b1;
    lock_nxt = 1'b0;
    seq_nxt = 1'b0;
    burst_nxt = 1'b0;
    if (doPop) begin
      reqN_nxt = 1'b0;
      curAddr_nxt = popCmd.addr;
      curWdata_nxt = popCmd.wdata;
      rnw_nxt = popCmd.ctrl[`CDMP_CTRL_WR];
      size_nxt = popCmd.ctrl[`CDMP_CTRL_SIZE_LO +: 2];
      lock_nxt = popCmd.ctrl[`CDMP_CTRL_LOCK];
      seq_nxt = popCmd.ctrl[`CDMP_CTRL_SEQ];
      burst_nxt = popCmd.ctrl[`CDMP_CTRL_BURST];
      priv_nxt = popCmd.ctrl[`CDMP_CTRL_PRIV];
      mode_nxt = popCmd.ctrl[`CDMP_CTRL_MODE_LO +: 5];
    end
    acc_nxt = !reqN_r;
    dmemAddr_nxt = !reqN_r ? curAddr_r : dmemAddr_r;
    wrDrv_nxt = !reqN_r && rnw_r;
    wdOut_nxt = wrDrv_nxt ? curWdata_r : wdOut_r;
    aOeN_nxt = split2_r ? 1'b0 : !abe2_r;
    wOeN_nxt = split2_r ? 1'b0 : !(wrDrv_nxt && ddbe2_r);
    tagS1_nxt = acc_r;
    rdS1_nxt = acc_r && !wrDrv_r;
    tagS2_nxt = tagS1_r;
    rdS2_nxt = rdS1_r;
    // Issue stops after an abort until software has seen and cleared it.
    unique case (state_r)
      CDMP_ISSUE: if (tagS2_r && abt2_r) state_nxt = CDMP_HALT;
      CDMP_HALT: if (!abortFlag_r) state_nxt = CDMP_ISSUE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addrReg_r <= '0;
      wdataReg_r <= '0;
      ctrlReg_r <= `CDMP_CTRL_RST;
      abortFlag_r <= 1'b0;
      sizeErr_r <= 1'b0;
      ovfl_r <= 1'b0;
      rdValid_r <= 1'b0;
      rdLast_r <= '0;
      busRdata_r <= '0;
      spaceAvail_r <= 1'b0;
      state_r <= CDMP_ISSUE;
      curAddr_r <= '0;
      curWdata_r <= '0;
      size_r <= `CDMP_SIZE_WORD;
      mode_r <= `CDMP_MODE_RST;
      rnw_r <= 1'b0;
      priv_r <= 1'b0;
      reqN_r <= 1'b1;
      lock_r <= 1'b0;
      seq_r <= 1'b0;
      burst_r <= 1'b0;
      acc_r <= 1'b0;
      dmemAddr_r <= '0;
      wrDrv_r <= 1'b0;
      wdOut_r <= '0;
      aOeN_r <= 1'b1;
      wOeN_r <= 1'b1;
      tagS1_r <= 1'b0;
      rdS1_r <= 1'b0;
      tagS2_r <= 1'b0;
      rdS2_r <= 1'b0;
    end else begin
      addrReg_r <= addrReg_nxt;
      wdataReg_r <= wdataReg_nxt;
      ctrlReg_r <= ctrlReg_nxt;
      abortFlag_r <= abortFlag_nxt;
      sizeErr_r <= sizeErr_nxt;
      ovfl_r <= ovfl_nxt;
      rdValid_r <= rdValid_nxt;
      rdLast_r <= rdLast_nxt;
      busRdata_r <= busRdata_nxt;
      spaceAvail_r <= pushReady;
      state_r <= state_nxt;
      curAddr_r <= curAddr_nxt;
      curWdata_r <= curWdata_nxt;
      size_r <= size_nxt;
      mode_r <= mode_nxt;
      rnw_r <= rnw_nxt;
      priv_r <= priv_nxt;
      reqN_r <= reqN_nxt;
      lock_r <= lock_nxt;
      seq_r <= seq_nxt;
      burst_r <= burst_nxt;
      acc_r <= acc_nxt;
      dmemAddr_r <= dmemAddr_nxt;
      wrDrv_r <= wrDrv_nxt;
      wdOut_r <= wdOut_nxt;
      aOeN_r <= aOeN_nxt;
      wOeN_r <= wOeN_nxt;
      tagS1_r <= tagS1_nxt;
      rdS1_r <= rdS1_nxt;
      tagS2_r <= tagS2_nxt;
      rdS2_r <= rdS2_nxt;
    end
  end

  assign busRdata = busRdata_r;
  assign cmdSpaceAvail = spaceAvail_r;
  assign dmemAddr = dmemAddr_r;
  assign addrGroupOeN = aOeN_r;
  assign accessSize = size_r;
  assign readNWrite = rnw_r;
  assign dmemLocked = lock_r;
  assign privilegedAccess = priv_r;
  assign accessMode = mode_r;
  assign dmemReqN = reqN_r;
  assign dmemSequential = seq_r;
  assign burstFollows = burst_r;
  assign writeDataOut = wdOut_r;
  assign writeDataOeN = wOeN_r;
  assign writeDataDriven = wrDrv_r;

  property p_addrAfterReq;
    @(posedge clk) disable iff (rst) !dmemReqN |=> dmemAddr == $past(curAddr_r);
  endproperty
  a_addrAfterReq: assert property (p_addrAfterReq) else $error("address late");
  property p_addrOeSplit;
    @(posedge clk) disable iff (rst) split2_r || abe2_r |=> !addrGroupOeN;
  endproperty
  a_addrOeSplit: assert property (p_addrOeSplit) else $error("address group floated");
  property p_wrOeFloat;
    @(posedge clk) disable iff (rst) !split2_r && !ddbe2_r |=> writeDataOeN;
  endproperty
  a_wrOeFloat: assert property (p_wrOeFloat) else $error("write bus not floated");
  property p_abortHalts;
    @(posedge clk) disable iff (rst) tagS2_r && abt2_r |=> abortFlag_r ##1 dmemReqN [*2];
  endproperty
  a_abortHalts: assert property (p_abortHalts) else $error("abort did not stop issue");
  property p_wrData;
    @(posedge clk) disable iff (rst)
      !dmemReqN && readNWrite |=> writeDataDriven && writeDataOut == $past(curWdata_r);
  endproperty
  a_wrData: assert property (p_wrData) else $error("write data not presented");
  property p_splitDrive;
    @(posedge clk) disable iff (rst) split2_r |=> !writeDataOeN;
  endproperty
  a_splitDrive: assert property (p_splitDrive) else $error("split bus floated");
  property p_noReservedSize;
    @(posedge clk) disable iff (rst) accessSize != `CDMP_SIZE_RSVD;
  endproperty
  a_noReservedSize: assert property (p_noReservedSize) else $error("reserved size code");
  property p_readNoDrive;
    @(posedge clk) disable iff (rst) !dmemReqN && !readNWrite |=> !writeDataDriven;
  endproperty
  a_readNoDrive: assert property (p_readNoDrive) else $error("read flagged as write");
  property p_attrIdle;
    @(posedge clk) disable iff (rst) dmemReqN |-> !dmemLocked && !dmemSequential && !burstFollows;
  endproperty
  a_attrIdle: assert property (p_attrIdle) else $error("stray attribute");

endmodule : cdmp_data_port
`default_nettype wire

// file: bench/cdmp_mem_model.sv
/*
  Behavioural memory on the far side of the data memory port.
  Assumes the port's request cycle is followed by exactly one access cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module cdmp_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic dmemReqN,
  input wire logic readNWrite,
  input wire logic dmemLocked,
  input wire logic [31:0] dmemAddr,
  input wire logic abortArm,
  output logic [31:0] readDataIn,
  output logic dmemAbort,
  output logic lockHeld
);
  logic accR;
  logic rnwR;
  logic [31:0] lastR;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accR <= 1'b0;
      rnwR <= 1'b0;
      lastR <= 32'h0;
      lockHeld <= 1'b0;
    end else begin
      accR <= !dmemReqN;
      rnwR <= readNWrite;
      lastR <= readDataIn;
      // No second master exists here, so the lock is only recorded.
      if (!dmemReqN) begin
        lockHeld <= dmemLocked;
      end
    end
  end

  // Outside a read the bus changes every cycle, so a port that samples late sees garbage.
  assign readDataIn = (accR && !rnwR) ? (dmemAddr ^ 32'h5a5a_a5a5) : ~lastR;
  assign dmemAbort = accR && abortArm;
endmodule : cdmp_mem_model

`default_nettype wire

// file: bench/cdmp_testbench.sv
/*
  Self-checking bench for the data memory port with its memory model.
  Assumes the register header and the package are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cdmp_regs.svh"

module testbench
  import cdmp_pkg::*;
;
  logic clk, busWr = 1'b0, busRd = 1'b0, rst = 1'b1, abortArm = 1'b0, lockHeld, rdSeen;
  logic split = 1'b0, abEn = 1'b1, wbEn = 1'b1, accNow = 1'b0, wantOe;
  logic [7:0] busAddr = 8'h0;
  logic [31:0] busWdata = 32'h0, busRdata, dmemAddr, writeDataOut, readDataIn;
  logic [31:0] seed = 32'hda51, lastAddr = 32'h0, a;
  logic cmdSpaceAvail, addrGroupOeN, readNWrite, dmemLocked, privilegedAccess, dmemReqN;
  logic dmemSequential, burstFollows, writeDataOeN, writeDataDriven, dmemAbort;
  logic [1:0] accessSize;
  logic [4:0] accessMode;
  logic [11:0] c, attr;
  int nMismatch = 0;
  int testsRun = 0;
  cdmp_cmd_s expQ[$];
  cdmp_cmd_s cur;
  logic [31:0] rdQ[$];

  cdmp_data_port dut_u (
    .clk(clk), .rst(rst), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .busRdata(busRdata), .cmdSpaceAvail(cmdSpaceAvail), .dmemAddr(dmemAddr),
    .addrGroupOeN(addrGroupOeN), .accessSize(accessSize), .readNWrite(readNWrite),
    .dmemLocked(dmemLocked), .privilegedAccess(privilegedAccess), .accessMode(accessMode),
    .dmemReqN(dmemReqN), .dmemSequential(dmemSequential), .burstFollows(burstFollows),
    .writeDataOut(writeDataOut), .writeDataOeN(writeDataOeN),
    .writeDataDriven(writeDataDriven), .readDataIn(readDataIn), .dmemAbort(dmemAbort),
    .addrBusDriveEn(abEn), .writeBusDriveEn(wbEn), .splitBusSelect(split)
  );

  cdmp_mem_model mem_u (
    .clk(clk), .rst(rst), .dmemReqN(dmemReqN), .readNWrite(readNWrite),
    .dmemLocked(dmemLocked), .dmemAddr(dmemAddr), .abortArm(abortArm),
    .readDataIn(readDataIn), .dmemAbort(dmemAbort), .lockHeld(lockHeld)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [11:0] expCtrl(input logic [11:0] v);
    return (v[2:1] == 2'h3) ? {v[11:3], 2'h2, v[0]} : v;
  endfunction : expCtrl

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic regWr(input logic [7:0] ad, input logic [31:0] d);
    busAddr <= ad;
    busWdata <= d;
    busWr <= 1'b1;
    busRd <= 1'b0;
    @(posedge clk);
  endtask : regWr

  task automatic regRd(input logic [7:0] ad, input logic [31:0] e);
    rdQ.push_back(e);
    busAddr <= ad;
    busWr <= 1'b0;
    busRd <= 1'b1;
    @(posedge clk);
  endtask : regRd

  task automatic idle(input int n);
    busWr <= 1'b0;
    busRd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic pushCmd(input logic [31:0] ad, input logic [11:0] v, input bit keep);
    cdmp_cmd_s e;
    e.addr = ad;
    e.wdata = xs();
    e.ctrl = expCtrl(v);
    if (keep) expQ.push_back(e);
    regWr(`CDMP_REG_ADDR, ad);
    regWr(`CDMP_REG_WDATA, e.wdata);
    regWr(`CDMP_REG_CTRL, {20'h0, v});
    regWr(`CDMP_REG_PUSH, 32'h0);
    idle(1);
  endtask : pushCmd

  task automatic wrapUp();
    $display("Checks %0d, mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrapUp

  always @(posedge clk) rdSeen <= busRd;

  // Sampling on the falling edge keeps the compare clear of the edge that updates the port.
  always @(negedge clk) begin
    if (!rst) begin
      if (rdSeen) check(busRdata, rdQ.pop_front(), "register read");
      if (accNow) begin
        check(dmemAddr, cur.addr, "address");
        check({31'h0, writeDataDriven}, {31'h0, cur.ctrl[0]}, "write flag");
        if (cur.ctrl[0]) check(writeDataOut, cur.wdata, "write data");
        wantOe = cur.ctrl[0] ? !(split || wbEn) : !split;
        check({31'h0, writeDataOeN}, {31'h0, wantOe}, "data enable");
        check({31'h0, lockHeld}, {31'h0, cur.ctrl[3]}, "lock seen");
        check({31'h0, addrGroupOeN}, {31'h0, !(split || abEn)}, "address enable");
        lastAddr = dmemAddr;
      end else begin
        check(dmemAddr, lastAddr, "address hold");
      end
      accNow = !dmemReqN;
      if (!dmemReqN) begin
        check({31'h0, expQ.size() != 0}, 32'h1, "unexpected request");
        cur = expQ.pop_front();
        attr = {accessMode, privilegedAccess, burstFollows, dmemSequential, dmemLocked,
          accessSize, readNWrite};
        check(32'(attr[11:5]), 32'(cur.ctrl[11:5]), "upper attributes");
        check(32'(attr[4:0]), 32'(cur.ctrl[4:0]), "lower attributes");
      end
    end
  end

  // About 300 cycles are needed; the margin covers a slow drain without hiding a hang.
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    $display("Error at %0t: watchdog expired", $time);
    wrapUp();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    check({21'h0, dmemReqN, addrGroupOeN, writeDataOeN, accessSize, accessMode, writeDataDriven},
      {21'h0, 3'h7, `CDMP_SIZE_WORD, `CDMP_MODE_RST, 1'b0}, "reset outputs");
    repeat (14) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    $display("test reset done");
    a = xs();
    regWr(`CDMP_REG_ADDR, a);
    regWr(`CDMP_REG_CTRL, 32'h0000_0fa5);
    regWr(8'h1c, 32'hffff_ffff);
    regRd(`CDMP_REG_ADDR, a);
    regRd(`CDMP_REG_CTRL, 32'h0000_0fa5);
    regRd(8'h18, 32'h0);
    regRd(`CDMP_REG_STATUS, 32'h0);
    idle(2);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      a = xs();
      c = {a[11:7], i[0], i[1], i[2], i[0] ^ i[1], i[1:0], i[2]};
      pushCmd(a, c, 1'b1);
      idle(8);
      if (!c[0]) regRd(`CDMP_REG_RDATA, a ^ 32'h5a5a_a5a5);
    end
    idle(2);
    regRd(`CDMP_REG_STATUS, 32'h0000_000a);
    idle(1);
    $display("test attributes done");
    for (int k = 0; k < 3; k++) begin
      split <= (k == 2);
      abEn <= (k == 0);
      wbEn <= (k == 0);
      idle(5);
      check({31'h0, addrGroupOeN}, 32'(k == 1), "idle address enable");
      check({31'h0, writeDataOeN}, 32'(k != 2), "idle data enable");
      pushCmd(xs(), 12'h805, 1'b1);
      pushCmd(xs(), 12'h804, 1'b1);
      idle(6);
    end
    split <= 1'b0;
    abEn <= 1'b1;
    wbEn <= 1'b1;
    idle(5);
    $display("test bus modes done");
    regWr(`CDMP_REG_STATUS, 32'hf);
    abortArm <= 1'b1;
    pushCmd(32'h0000_1000, 12'h805, 1'b1);
    idle(10);
    abortArm <= 1'b0;
    for (int j = 0; j < 9; j++) pushCmd(32'h2000 + 32'(j * 4), 12'h835, j < 8);
    regRd(`CDMP_REG_STATUS, 32'h0000_0835);
    idle(1);
    check({31'h0, cmdSpaceAvail}, 32'h0, "space while full");
    check({31'h0, dmemReqN}, 32'h1, "request while halted");
    regWr(`CDMP_REG_STATUS, 32'h1);
    idle(20);
    regRd(`CDMP_REG_STATUS, 32'h0000_0004);
    idle(1);
    check({31'h0, cmdSpaceAvail}, 32'h1, "space after drain");
    check(32'(expQ.size()), 32'h0, "accesses left");
    $display("test abort and fill done");
    idle(4);
    wrapUp();
  end
endmodule : testbench

`default_nettype wire
